// file: hw/dfm_monitor.sv
// Drive fault monitor: limits, persistence and latched faults
//
// Overview of operation
// - Each fault latches until cleared by fieldbus, digital input or UI.
// - Short circuit on regen, upper or lower switch short signal.
// - Bus over-voltage when bus above upper limit over 6 ms.
// - Regen fault on init failure or filtered power above capability.
// - Ambient over-temperature when above maximum over 3 s.
// - Bridge over-temperature when above maximum over 300 ms.
// - Motor over-temperature when above maximum over 300 ms.
// - Encoder fault when mask nonzero and a selector chooses encoder.
// - Encoder mask: comms, amplitude loss, type, gain, offset bits.
// - Encoder fault when encoder supply off nominal by 15% over 30 ms.
// - Resolver fault when a selector chooses resolver and status is 2.
// - Resolver status set when squared sums over 2^16 reach 8000.
// - Logic supply fault when 3.3 V or +-15 V rails out over 30 ms.
// - Logic supply fault when 24 V below power-down limit 2 ms.
// - Logic supply fault at once when 2.5 V reference out of window.
// - Database fault on address, start-up, storage or background errors.
// - Bus fault when bus below lower limit over 6 ms.
// - Bus fault when sample step exceeds rate limit times 2 ms.
// - Current loop fault when phase A or B offset beyond limit.
// - Board fault on flash, logic, loop-back or serial setup failure.
// - Programming fault on database, task, overrun or exception error.
`timescale 1ns/1ps
`default_nettype none
module dfm_monitor #(
  parameter int unsigned CYC_BUS    = dfm_pkg::CYC_BUS,
  parameter int unsigned CYC_AMB    = dfm_pkg::CYC_AMB,
  parameter int unsigned CYC_TEMP   = dfm_pkg::CYC_TEMP,
  parameter int unsigned CYC_SUPPLY = dfm_pkg::CYC_SUPPLY,
  parameter int unsigned CYC_PDOWN  = dfm_pkg::CYC_PDOWN
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic        [7:0]  reg_addr,
  input  wire logic        [31:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic             [31:0] reg_rdata,
  input  wire logic               clr_fieldbus,
  input  wire logic               clr_din,
  input  wire logic               sc_regen,
  input  wire logic               sc_upper,
  input  wire logic               sc_lower,
  input  wire logic               regen_init_fail,
  input  wire logic signed [15:0] regen_power,
  input  wire logic signed [15:0] bus_voltage,
  input  wire logic               bus_sample,
  input  wire logic signed [15:0] ambient_temp,
  input  wire logic signed [15:0] bridge_temp,
  input  wire logic signed [15:0] motor_temp,
  input  wire logic        [4:0]  enc_fault_mask,
  input  wire logic signed [15:0] enc_supply,
  input  wire logic signed [15:0] res_sine_sum,
  input  wire logic signed [15:0] res_cosine_sum,
  input  wire logic signed [15:0] supply_3v3,
  input  wire logic signed [15:0] supply_p15,
  input  wire logic signed [15:0] supply_n15,
  input  wire logic signed [15:0] supply_24v,
  input  wire logic signed [15:0] supply_ref,
  input  wire logic signed [15:0] ia_offset,
  input  wire logic signed [15:0] ib_offset,
  input  wire logic        [3:0]  nvm_err,
  input  wire logic        [3:0]  board_err,
  input  wire logic        [3:0]  prog_err,
  output logic             [15:0] fault_word,
  output logic                    fault_any
);
  localparam int NL = dfm_pkg::NUM_LIM;
  localparam int NT = dfm_pkg::NUM_TMR;
  localparam int unsigned TMR_CYC [NT] = '{
    CYC_BUS, CYC_BUS, CYC_AMB, CYC_TEMP, CYC_TEMP,
    CYC_SUPPLY, CYC_SUPPLY, CYC_SUPPLY, CYC_SUPPLY, CYC_PDOWN};

  typedef struct packed {
    logic        [15:0]       fault;
    logic        [7:0]        cfg;
    logic        [1:0]        res_stat;
    logic signed [15:0]       bus_prev;
    logic                     prev_ok;
    logic        [31:0]       rdata;
    logic        [NL-1:0][15:0] lim;
  } dfm_state_t;

  localparam dfm_state_t ST_RST = '{
    fault: '0, cfg: dfm_pkg::CFG_RST,
    res_stat: dfm_pkg::RES_ST_OK, bus_prev: '0,
    prev_ok: 1'b0, rdata: '0, lim: dfm_pkg::LIM_RST};

  dfm_state_t q;
  dfm_state_t d;

  // ==========================================================
  // Shared decoders
  function automatic logic out_win(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi);
    return (v < lo) || (v > hi);
  endfunction : out_win

  function automatic logic sel_any(
    input logic [7:0] cfg,
    input logic [1:0] code);
    return (cfg[dfm_pkg::CFG_COMM +: 2] == code) ||
           (cfg[dfm_pkg::CFG_POS +: 2] == code) ||
           (cfg[dfm_pkg::CFG_VEL +: 2] == code);
  endfunction : sel_any

  function automatic logic out_sym(
    input logic signed [15:0] v,
    input logic        [15:0] lim);
    logic signed [16:0] vw;
    logic signed [16:0] lw;
    vw = {v[15], v};
    lw = {1'b0, lim};
    return (vw > lw) || (vw < -lw);
  endfunction : out_sym

  // ==========================================================
  // Register decode
  logic [7:0]  lim_off;
  logic [3:0]  lim_idx;
  logic        lim_hit;
  logic        clr_any;

  assign lim_off = reg_addr - dfm_pkg::A_LIM_BASE;
  assign lim_idx = lim_off[5:2];
  assign lim_hit = (reg_addr >= dfm_pkg::A_LIM_BASE) &&
                   (lim_off[7:2] < 6'(NL)) &&
                   (lim_off[1:0] == 2'b00);
  // Any of the three requesters clears every latch
  assign clr_any = clr_fieldbus || clr_din ||
                   (reg_wr && reg_addr == dfm_pkg::A_CLEAR &&
                    reg_wdata[dfm_pkg::CLR_BIT]);

  // ==========================================================
  // Derived quantities
  logic signed [31:0] sin_sq;
  logic signed [31:0] cos_sq;
  logic        [32:0] res_sum;
  logic               res_bad;
  logic        [15:0] enc_nom;
  logic signed [15:0] enc_lo;
  logic signed [15:0] enc_hi;
  logic signed [16:0] dv;
  logic        [16:0] dv_abs;
  logic        [16:0] dv_max;
  logic               dv_bad;

  // Squares never go negative, so zero-extend the sum
  assign sin_sq  = res_sine_sum * res_sine_sum;
  assign cos_sq  = res_cosine_sum * res_cosine_sum;
  assign res_sum = {1'b0, sin_sq} + {1'b0, cos_sq};
  assign res_bad = res_sum[32:dfm_pkg::RES_SH] >= dfm_pkg::RES_THR;

  // Nominal encoder supply; code 3 also means 12 V
  always_comb
  begin
    unique case (q.cfg[dfm_pkg::CFG_ENC +: 2])
      2'h0:    enc_nom = dfm_pkg::ENC_5V;
      2'h1:    enc_nom = dfm_pkg::ENC_8V;
      default: enc_nom = dfm_pkg::ENC_12V;
    endcase
  end
  assign enc_lo = 16'((32'(enc_nom) * (100 - dfm_pkg::ENC_TOL)) / 100);
  assign enc_hi = 16'((32'(enc_nom) * (100 + dfm_pkg::ENC_TOL)) / 100);

  // Step between bus samples against rate limit times 2 ms
  assign dv     = {bus_voltage[15], bus_voltage} -
                  {q.bus_prev[15], q.bus_prev};
  assign dv_abs = dv[16] ? 17'(-dv) : 17'(dv);
  assign dv_max = 17'({1'b0, q.lim[dfm_pkg::LIM_DVDT]} *
                      dfm_pkg::T_DVDT_MS);
  assign dv_bad = bus_sample && q.prev_ok && (dv_abs > dv_max);

  // ==========================================================
  // Persistence timers, one per supervised level
  logic [NT-1:0] tcond;
  logic [NT-1:0] tmr_exp;

  always_comb
  begin
    tcond = '0;
    tcond[dfm_pkg::TM_OV]  = bus_voltage >
                             $signed(q.lim[dfm_pkg::LIM_OV]);
    tcond[dfm_pkg::TM_UV]  = bus_voltage <
                             $signed(q.lim[dfm_pkg::LIM_UV]);
    tcond[dfm_pkg::TM_AMB] = ambient_temp >
                             $signed(q.lim[dfm_pkg::LIM_AMB]);
    tcond[dfm_pkg::TM_BRG] = bridge_temp >
                             $signed(q.lim[dfm_pkg::LIM_BRG]);
    tcond[dfm_pkg::TM_MOT] = motor_temp >
                             $signed(q.lim[dfm_pkg::LIM_MOT]);
    tcond[dfm_pkg::TM_ENC] = out_win(enc_supply, enc_lo, enc_hi);
    tcond[dfm_pkg::TM_3V3] = out_win(supply_3v3,
                             dfm_pkg::V33_LO, dfm_pkg::V33_HI);
    tcond[dfm_pkg::TM_P15] = out_win(supply_p15,
                             dfm_pkg::P15_LO, dfm_pkg::P15_HI);
    tcond[dfm_pkg::TM_N15] = out_win(supply_n15,
                             dfm_pkg::N15_LO, dfm_pkg::N15_HI);
    tcond[dfm_pkg::TM_24V] = supply_24v <
                             $signed(q.lim[dfm_pkg::LIM_PD]);
  end

  for (genvar i = 0; i < NT; i++)
  begin : g_tmr
    dfm_persist #(
      .CYC     (TMR_CYC[i])
    ) u_tmr (
      .clk     (clk),
      .reset   (reset),
      .cond    (tcond[i]),
      .expired (tmr_exp[i])
    );
  end

  // ==========================================================
  // Fault set terms
  logic [15:0] set_vec;
  logic        enc_hit;
  logic        ref_bad;

  assign enc_hit = (enc_fault_mask != 5'h00) &&
                   sel_any(q.cfg, dfm_pkg::SEL_ENC);
  assign ref_bad = out_win(supply_ref,
                           dfm_pkg::REF_LO, dfm_pkg::REF_HI);

  always_comb
  begin
    set_vec = '0;
    set_vec[dfm_pkg::F_SHORT] = sc_regen || sc_upper || sc_lower;
    set_vec[dfm_pkg::F_OVERV] = tmr_exp[dfm_pkg::TM_OV];
    set_vec[dfm_pkg::F_REGEN] = regen_init_fail ||
      (regen_power > $signed(q.lim[dfm_pkg::LIM_REGEN]));
    set_vec[dfm_pkg::F_AMB]   = tmr_exp[dfm_pkg::TM_AMB];
    set_vec[dfm_pkg::F_BRG]   = tmr_exp[dfm_pkg::TM_BRG];
    set_vec[dfm_pkg::F_MOT]   = tmr_exp[dfm_pkg::TM_MOT];
    set_vec[dfm_pkg::F_ENC]   = enc_hit ||
                                tmr_exp[dfm_pkg::TM_ENC];
    set_vec[dfm_pkg::F_RES]   = sel_any(q.cfg, dfm_pkg::SEL_RES) &&
      (q.res_stat == dfm_pkg::RES_ST_BAD);
    set_vec[dfm_pkg::F_LOGIC] = tmr_exp[dfm_pkg::TM_3V3] ||
      tmr_exp[dfm_pkg::TM_P15] || tmr_exp[dfm_pkg::TM_N15] ||
      tmr_exp[dfm_pkg::TM_24V] || ref_bad;
    set_vec[dfm_pkg::F_NVM]   = |nvm_err;
    set_vec[dfm_pkg::F_BUS]   = tmr_exp[dfm_pkg::TM_UV] ||
                                dv_bad;
    set_vec[dfm_pkg::F_PROG]  = |prog_err;
    set_vec[dfm_pkg::F_CURR]  = out_sym(ia_offset,
      q.lim[dfm_pkg::LIM_ADC]) ||
      out_sym(ib_offset, q.lim[dfm_pkg::LIM_ADC]);
    set_vec[dfm_pkg::F_BOARD] = |board_err;
  end

  // ==========================================================
  // Next state: latches, registers, bus sample history
  always_comb
  begin
    d = q;
    d.rdata = '0;
    // A new event beats a clear in the same cycle
    d.fault = (q.fault & ~{16{clr_any}}) | set_vec;
    d.res_stat = res_bad ? dfm_pkg::RES_ST_BAD
                         : dfm_pkg::RES_ST_OK;
    if (bus_sample)
    begin
      d.bus_prev = bus_voltage;
      d.prev_ok  = 1'b1;
    end
    if (reg_wr)
    begin
      if (reg_addr == dfm_pkg::A_CONFIG)
        d.cfg = reg_wdata[7:0];
      if (lim_hit)
        d.lim[lim_idx] = reg_wdata[15:0];
    end
    // Unmapped or write-only addresses read as zero
    if (reg_rd)
    begin
      if (lim_hit)
        d.rdata = 32'(q.lim[lim_idx]);
      else if (reg_addr == dfm_pkg::A_FAULT)
        d.rdata = 32'(q.fault);
      else if (reg_addr == dfm_pkg::A_STATUS)
        d.rdata = 32'({q.res_stat, enc_fault_mask});
      else if (reg_addr == dfm_pkg::A_CONFIG)
        d.rdata = 32'(q.cfg);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      q <= ST_RST;
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign reg_rdata  = q.rdata;
  assign fault_word = q.fault;
  assign fault_any  = |q.fault;

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence enc_request;
    (enc_fault_mask != 5'h00) && sel_any(q.cfg, dfm_pkg::SEL_ENC);
  endsequence
  sequence bus_step;
    bus_sample && q.prev_ok ##0 dv_abs > dv_max;
  endsequence

  fault_hold_a: assert property (!clr_any |=>
      (fault_word & $past(fault_word)) == $past(fault_word))
    else $error("latched fault dropped without clear");
  fault_clear_a: assert property (clr_any && set_vec == '0 |=>
      fault_word == '0)
    else $error("clear request ignored");
  short_latch_a: assert property (sc_upper || sc_lower ||
      sc_regen |=> fault_word[dfm_pkg::F_SHORT])
    else $error("short circuit not latched");
  overvolt_cause_a: assert property (
      $rose(fault_word[dfm_pkg::F_OVERV]) |->
      $past(tmr_exp[dfm_pkg::TM_OV]))
    else $error("over-voltage without persistence");
  regen_power_a: assert property (
      regen_power > $signed(q.lim[dfm_pkg::LIM_REGEN]) |=>
      fault_word[dfm_pkg::F_REGEN])
    else $error("regen overload not latched");
  bridge_cause_a: assert property (
      $rose(fault_word[dfm_pkg::F_BRG]) |->
      $past(tmr_exp[dfm_pkg::TM_BRG]))
    else $error("bridge fault without persistence");
  enc_fault_a: assert property (enc_request |=>
      fault_word[dfm_pkg::F_ENC])
    else $error("encoder fault not latched");
  res_status_a: assert property (res_bad |=> ##1
      fault_word[dfm_pkg::F_RES] ||
      !$past(sel_any(q.cfg, dfm_pkg::SEL_RES)))
    else $error("resolver fault not raised");
  ref_window_a: assert property (ref_bad |=>
      fault_word[dfm_pkg::F_LOGIC])
    else $error("reference fault not immediate");
  bus_step_a: assert property (bus_step |=>
      fault_word[dfm_pkg::F_BUS])
    else $error("bus step not flagged");
  current_ofs_a: assert property (
      out_sym(ia_offset, q.lim[dfm_pkg::LIM_ADC]) |=>
      fault_word[dfm_pkg::F_CURR])
    else $error("current offset not flagged");
endmodule : dfm_monitor
`default_nettype wire

// file: pkg/dfm_pkg.sv
// Constants and register layout of the drive fault monitor
package dfm_pkg;
  // ==========================================================
  // Clock and persistence times
  localparam int unsigned CLK_MHZ     = 20;
  localparam int unsigned T_BUS_US    = 6_000;
  localparam int unsigned T_AMB_US    = 3_000_000;
  localparam int unsigned T_TEMP_US   = 300_000;
  localparam int unsigned T_SUPPLY_US = 30_000;
  localparam int unsigned T_PDOWN_US  = 2_000;
  localparam int unsigned T_DVDT_MS   = 2;
  localparam int unsigned CYC_BUS     = T_BUS_US * CLK_MHZ;
  localparam int unsigned CYC_AMB     = T_AMB_US * CLK_MHZ;
  localparam int unsigned CYC_TEMP    = T_TEMP_US * CLK_MHZ;
  localparam int unsigned CYC_SUPPLY  = T_SUPPLY_US * CLK_MHZ;
  localparam int unsigned CYC_PDOWN   = T_PDOWN_US * CLK_MHZ;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_FAULT    = 8'h00;
  localparam logic [7:0] A_CLEAR    = 8'h04;
  localparam logic [7:0] A_STATUS   = 8'h08;
  localparam logic [7:0] A_CONFIG   = 8'h0C;
  localparam logic [7:0] A_LIM_BASE = 8'h10;
  localparam int         CLR_BIT    = 0;

  // Config fields: feedback selectors and encoder nominal
  localparam int         CFG_COMM   = 0;
  localparam int         CFG_POS    = 2;
  localparam int         CFG_VEL    = 4;
  localparam int         CFG_ENC    = 6;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [1:0] SEL_RES    = 2'h1;
  localparam logic [1:0] SEL_ENC    = 2'h2;
  localparam logic [1:0] RES_ST_OK  = 2'h0;
  localparam logic [1:0] RES_ST_BAD = 2'h2;

  // ==========================================================
  // Limit table indices and reset values
  localparam int LIM_OV    = 0;
  localparam int LIM_UV    = 1;
  localparam int LIM_DVDT  = 2;
  localparam int LIM_AMB   = 3;
  localparam int LIM_BRG   = 4;
  localparam int LIM_MOT   = 5;
  localparam int LIM_REGEN = 6;
  localparam int LIM_PD    = 7;
  localparam int LIM_ADC   = 8;
  localparam int NUM_LIM   = 9;
  // Index 8 first: upper limits open, lower limits at zero
  localparam logic [NUM_LIM-1:0][15:0] LIM_RST = {
    16'h7FFF, 16'h0000, 16'h7FFF, 16'h7FFF, 16'h7FFF,
    16'h7FFF, 16'h7FFF, 16'h0000, 16'h7FFF};

  // ==========================================================
  // Fault word bit positions
  localparam int F_SHORT = 0;
  localparam int F_OVERV = 1;
  localparam int F_REGEN = 2;
  localparam int F_AMB   = 3;
  localparam int F_BRG   = 4;
  localparam int F_MOT   = 5;
  localparam int F_ENC   = 6;
  localparam int F_RES   = 7;
  localparam int F_LOGIC = 8;
  localparam int F_NVM   = 9;
  localparam int F_BUS   = 11;
  localparam int F_PROG  = 12;
  localparam int F_CURR  = 13;
  localparam int F_BOARD = 14;

  // Persistence timer slots
  localparam int TM_OV   = 0;
  localparam int TM_UV   = 1;
  localparam int TM_AMB  = 2;
  localparam int TM_BRG  = 3;
  localparam int TM_MOT  = 4;
  localparam int TM_ENC  = 5;
  localparam int TM_3V3  = 6;
  localparam int TM_P15  = 7;
  localparam int TM_N15  = 8;
  localparam int TM_24V  = 9;
  localparam int NUM_TMR = 10;

  // ==========================================================
  // Supply windows in millivolts, encoder tolerance and resolver threshold
  localparam logic signed [15:0] V33_LO  = 16'sh0B40;
  localparam logic signed [15:0] V33_HI  = 16'sh0E56;
  localparam logic signed [15:0] P15_LO  = 16'sh31CE;
  localparam logic signed [15:0] P15_HI  = 16'sh4362;
  localparam logic signed [15:0] N15_LO  = -16'sh4362;
  localparam logic signed [15:0] N15_HI  = -16'sh31CE;
  localparam logic signed [15:0] REF_LO  = 16'sh08CA;
  localparam logic signed [15:0] REF_HI  = 16'sh0ABE;
  localparam logic        [15:0] ENC_5V  = 16'h1388;
  localparam logic        [15:0] ENC_8V  = 16'h1F40;
  localparam logic        [15:0] ENC_12V = 16'h2EE0;
  localparam int unsigned        ENC_TOL = 15;
  localparam int                 RES_SH  = 16;
  localparam logic        [16:0] RES_THR = 17'h0_1F40;
endpackage : dfm_pkg

// file: hw/dfm_persist.sv
// Persistence timer: flags a condition held past a count
`timescale 1ns/1ps
`default_nettype none
module dfm_persist #(
  parameter int unsigned CYC = 4
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic cond,
  output logic      expired
);
  localparam int unsigned  W    = $clog2(CYC + 1);
  localparam logic [W-1:0] LAST = W'(CYC);

  typedef struct packed {
    logic [W-1:0] cnt;
  } dfm_tmr_t;

  dfm_tmr_t q;
  dfm_tmr_t d;

  // ==========================================================
  // Count while held, restart on any gap, saturate at end
  always_comb
  begin
    d = q;
    if (!cond)
      d.cnt = '0;
    else if (q.cnt != LAST)
      d.cnt = q.cnt + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      q <= '{cnt: '0};
    else
      q <= d;
  end

  // Fires only after CYC+1 held cycles, i.e. more than CYC
  assign expired = cond && (q.cnt == LAST);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  gap_restart_a: assert property (!cond |=> q.cnt == '0)
    else $error("timer not restarted after gap");
  expire_when_a: assert property ($rose(expired) |->
      $past(cond) && ($past(q.cnt) == LAST - 1'b1 || $past(q.cnt) == LAST))
    else $error("timer fired early");
endmodule : dfm_persist
`default_nettype wire

// file: sim/dfm_partner.sv
// Far-side model: power stage flags and measured drive quantities
`timescale 1ns/1ps
`default_nettype none
module dfm_partner (
  output logic               sc_regen,
  output logic               sc_upper,
  output logic               sc_lower,
  output logic               regen_init_fail,
  output logic               bus_sample,
  output logic        [4:0]  enc_fault_mask,
  output logic        [3:0]  nvm_err,
  output logic        [3:0]  board_err,
  output logic        [3:0]  prog_err,
  output logic signed [15:0] regen_power,
  output logic signed [15:0] bus_voltage,
  output logic signed [15:0] ambient_temp,
  output logic signed [15:0] bridge_temp,
  output logic signed [15:0] motor_temp,
  output logic signed [15:0] enc_supply,
  output logic signed [15:0] res_sine_sum,
  output logic signed [15:0] res_cosine_sum,
  output logic signed [15:0] supply_3v3,
  output logic signed [15:0] supply_p15,
  output logic signed [15:0] supply_n15,
  output logic signed [15:0] supply_24v,
  output logic signed [15:0] supply_ref,
  output logic signed [15:0] ia_offset,
  output logic signed [15:0] ib_offset
);
  // ==========================================================
  // Held values, healthy at start; slot 0 is the lowest field
  logic [21:0]       f_q = 22'h00_0000;
  logic [14:0][15:0] q_q = {16'h0000, 16'h0000, 16'h09C4, 16'h5DC0,
    16'hC568, 16'h3A98, 16'h0CE4, 16'h3F40, 16'h0000, 16'h1388,
    16'h0000, 16'h0000, 16'h0000, 16'h0320, 16'h0000};

  // Flags and quantities fan out to the ports
  assign {prog_err, board_err, nvm_err, enc_fault_mask, bus_sample,
    regen_init_fail, sc_lower, sc_upper, sc_regen} = f_q;
  assign {ib_offset, ia_offset, supply_ref, supply_24v, supply_n15,
    supply_p15, supply_3v3, res_cosine_sum, res_sine_sum, enc_supply,
    motor_temp, bridge_temp, ambient_temp, bus_voltage, regen_power} = q_q;

  // Non-blocking so a change never races the sampling edge
  task automatic set_f(input int i, input logic v);
    f_q[i] <= v;
  endtask : set_f

  task automatic set_q(input int i, input logic [15:0] v);
    q_q[i] <= v;
  endtask : set_q
endmodule : dfm_partner
`default_nettype wire

// file: sim/tb_top.sv
// Testbench: register access and fault scenarios for the monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Signals shared by design and partner, joined by name
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic clr_fieldbus = 1'b0, clr_din = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  wire logic [31:0] reg_rdata;
  wire logic [15:0] fault_word;
  wire logic fault_any, sc_regen, sc_upper, sc_lower, regen_init_fail;
  wire logic bus_sample;
  wire logic [4:0] enc_fault_mask;
  wire logic [3:0] nvm_err, board_err, prog_err;
  wire logic signed [15:0] regen_power, bus_voltage, ambient_temp,
    bridge_temp, motor_temp, enc_supply, res_sine_sum, res_cosine_sum,
    supply_3v3, supply_p15, supply_n15, supply_24v, supply_ref,
    ia_offset, ib_offset;
  int fails = 0;
  int checked = 0;
  // Limits, ADC (index 8) first; upper half of each write is junk on purpose
  localparam logic [8:0][15:0] LIMS = {16'h00C8, 16'h4E20, 16'h0064,
    16'h0064, 16'h0064, 16'h0064, 16'h000A, 16'h01F4, 16'h03E8};

  // Short persistence counts keep the run brief
  dfm_monitor #(.CYC_BUS(8), .CYC_AMB(12), .CYC_TEMP(6),
    .CYC_SUPPLY(10), .CYC_PDOWN(5)) u_dfm_monitor (.*);
  dfm_partner u_dfm_partner (.*);

  initial forever #25 clk = ~clk;

  // ==========================================================
  // Comparisons and bus cycles; checks run 1 ns after an edge
  task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %0t read %h exp %h", $time, g, e);
    end
  endtask : chk_rd

  task automatic chk_fw(input logic [15:0] e);
    checked++;
    if (fault_word !== e || fault_any !== (|e))
    begin
      fails++;
      $display("CHECK FAILED %0t faults %h exp %h", $time, fault_word, e);
    end
  endtask : chk_fw

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Data stand one cycle only, then must fall back to zero
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_rd(reg_rdata, e);
    @(posedge clk);
    #1 chk_rd(reg_rdata, 32'h0000_0000);
    @(posedge clk);
  endtask : rd

  // Clear by fieldbus, digital input or register in turn
  task automatic clr(input int k);
    @(posedge clk);
    if (k == 2)
      wr(dfm_pkg::A_CLEAR, 32'h0000_0001);
    else
    begin
      if (k == 0) clr_fieldbus <= 1'b1;
      else clr_din <= 1'b1;
      @(posedge clk);
      clr_fieldbus <= 1'b0;
      clr_din <= 1'b0;
    end
    // Long enough for a wrongly armed timer to trip
    repeat (14) @(posedge clk);
    #1 chk_fw(16'h0000);
  endtask : clr

  // Bad value, with one healthy gap when n > 0, then held; good value at boundary
  task automatic tq(input int i, input logic [15:0] bad, good,
                    input int n, b);
    u_dfm_partner.set_q(i, bad);
    if (n > 0)
    begin
      repeat (n) @(posedge clk);
      u_dfm_partner.set_q(i, good);
      @(posedge clk);
      u_dfm_partner.set_q(i, bad);
      // N held edges stay quiet; the next held edge latches the fault
      repeat (n) @(posedge clk);
      #1 chk_fw(16'h0000);
    end
    else @(posedge clk);
    @(posedge clk);
    #1 chk_fw(16'h0001 << b);
    @(posedge clk);
    rd(dfm_pkg::A_FAULT, {16'h0000, 16'h0001 << b});
    u_dfm_partner.set_q(i, good);
    clr(i % 3);
  endtask : tq

  task automatic pulse(input logic [15:0] v);
    u_dfm_partner.set_q(1, v);
    u_dfm_partner.set_f(4, 1'b1);
    @(posedge clk);
    u_dfm_partner.set_f(4, 1'b0);
    repeat (2) @(posedge clk);
  endtask : pulse

  function automatic logic [15:0] fbit(input int i, p);
    int b;
    b = i < 3 ? 0 : i == 3 ? 2 : i < 10 ? (p ? 6 : -1) :
        i < 14 ? 9 : i < 18 ? 14 : 12;
    return b < 0 ? 16'h0000 : 16'h0001 << b;
  endfunction : fbit

  task automatic end_of_test();
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(dfm_pkg::A_CONFIG, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h30, 32'h0000_7FFF);
    rd(dfm_pkg::A_CLEAR, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    for (int k = 0; k < 9; k++)
      wr(8'(dfm_pkg::A_LIM_BASE + 4 * k), {16'hFFFF, LIMS[k]});
    rd(dfm_pkg::A_LIM_BASE, 32'h0000_03E8);
    for (int p = 0; p < 2; p++)
    begin
      wr(dfm_pkg::A_CONFIG, p ? 32'h0000_0024 : 32'h0000_0000);
      for (int i = 0; i < 22; i++)
        if (i != 4)
        begin
          u_dfm_partner.set_f(i, 1'b1);
          @(posedge clk);
          #1 chk_fw(fbit(i, p));
          @(posedge clk);
          if (i > 4 && i < 10)
            rd(dfm_pkg::A_STATUS, 32'h0000_0001 << (i - 5));
          u_dfm_partner.set_f(i, 1'b0);
          clr(i % 3);
        end
    end
    rd(dfm_pkg::A_CONFIG, 32'h0000_0024);
    tq(1, 16'h03E9, 16'h03E8, 8, 1);
    tq(1, 16'h01F3, 16'h01F4, 8, 11);
    tq(2, 16'h0065, 16'h0064, 12, 3);
    tq(3, 16'h0065, 16'h0064, 6, 4);
    tq(4, 16'h0065, 16'h0064, 6, 5);
    tq(5, 16'h1099, 16'h109A, 10, 6);
    tq(8, 16'h0B3F, 16'h0B40, 10, 8);
    tq(9, 16'h4363, 16'h4362, 10, 8);
    tq(10, 16'hCE33, 16'hCE32, 10, 8);
    tq(11, 16'h4E1F, 16'h4E20, 5, 8);
    tq(0, 16'h0065, 16'h0064, 0, 2);
    tq(6, 16'h3F3E, 16'h3F3D, 0, 7);
    tq(12, 16'h08C9, 16'h08CA, 0, 8);
    tq(13, 16'h00C9, 16'h00C8, 0, 13);
    tq(14, 16'hFF37, 16'hFF38, 0, 13);
    @(posedge clk);
    pulse(16'h0320);
    pulse(16'h0334);
    #1 chk_fw(16'h0000);
    @(posedge clk);
    pulse(16'h0349);
    #1 chk_fw(16'h0800);
    clr(0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
